// ===== core/dbg_pkg.sv
package dbg_pkg;

  // debug entry causes, three-bit field in the control/status word
  localparam logic [2:0] CAUSE_BREAK   = 3'h1;
  localparam logic [2:0] CAUSE_TRIGGER = 3'h2;
  localparam logic [2:0] CAUSE_REQUEST = 3'h3;
  localparam logic [2:0] CAUSE_NONE    = 3'h0;

  // control/status field positions
  localparam int DCS_CAUSE_LSB = 6;
  localparam int DCS_BRK_BIT   = 15;
  localparam int DCS_PRV_LSB   = 0;
  localparam logic [1:0] PRV_MACHINE = 2'h3;
  localparam logic [3:0] DCS_XDEBUG  = 4'h4;
  localparam int DCS_XDBG_LSB  = 28;

  // trigger data one layout: type in top nibble, debug-only bit below it
  localparam int TD1_TRIGGER_DEBUG_ONLY_BIT = 27;
  localparam int TD1_EXEC_BIT  = 2;
  localparam logic [3:0] TD1_TYPE_MATCH = 4'h2;
  localparam int TD1_TYPE_LSB  = 28;

  // machine trap cause codes for a breakpoint and an illegal csr access
  localparam logic [31:0] CAUSE_CODE_BREAK   = 32'h0000_0003;
  localparam logic [31:0] CAUSE_CODE_ILLEGAL = 32'h0000_0002;

  // handshake to reach the debug csrs and the trigger registers
  localparam int CSR_SEL_W = 3;
  localparam logic [2:0] SEL_DCSR  = 3'h0;
  localparam logic [2:0] SEL_DPC   = 3'h1;
  localparam logic [2:0] SEL_SCR0  = 3'h2;
  localparam logic [2:0] SEL_SCR1  = 3'h3;
  localparam logic [2:0] SEL_TD1   = 3'h4;
  localparam logic [2:0] SEL_TD2   = 3'h5;

  // reset phase: cycles held in have-reset after fetch permit sampled
  localparam int HAVERESET_CYC = 2;

  // instruction retirement events from the pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic        is_ebreak;
    logic        is_mret;
    logic        is_dret;
    logic        except;
  } retire_t;

  // csr access from the pipeline
  typedef struct packed {
    logic                 req;
    logic                 we;
    logic [CSR_SEL_W-1:0] sel;
    logic [31:0]          wdata;
  } csr_req_t;

  typedef enum logic [3:0] {
    ST_RESET   = 4'b0001,
    ST_WAIT    = 4'b0010,
    ST_RUN     = 4'b0100,
    ST_HALT    = 4'b1000
  } dbg_state_t;

endpackage

// ===== core/dbg_trigger.sv
`timescale 1ns/10ps
module dbg_trigger #(
  parameter int XLEN = 32
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // register access
  input  wire logic            wr_td1,
  input  wire logic            wr_td2,
  input  wire logic [XLEN-1:0] wdata,
  input  wire logic            in_debug,
  // address compare
  input  wire logic [XLEN-1:0] fetch_pc,
  input  wire logic            fetch_valid,
  output logic      [XLEN-1:0] td1_rd,
  output logic      [XLEN-1:0] td2_rd,
  output logic                 hit
);

  logic            exec_en_ff;
  logic [XLEN-1:0] match_addr_ff;
  logic            wr_ok1;
  logic            wr_ok2;

  // (R13) writes gated outside debug
  assign wr_ok1 = wr_td1 & in_debug;
  assign wr_ok2 = wr_td2 & in_debug;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      exec_en_ff    <= 1'b0;
      match_addr_ff <= '0;
    end else begin
      if (wr_ok1) exec_en_ff <= wdata[dbg_pkg::TD1_EXEC_BIT];
      if (wr_ok2) match_addr_ff <= wdata;
    end
  end

  // (R13) debug-only bit reads one
  assign td1_rd = {dbg_pkg::TD1_TYPE_MATCH, 1'b1,
                   {(dbg_pkg::TD1_TRIGGER_DEBUG_ONLY_BIT - dbg_pkg::TD1_EXEC_BIT - 1){1'b0}},
                   exec_en_ff, {dbg_pkg::TD1_EXEC_BIT{1'b0}}};
  assign td2_rd = match_addr_ff;

  // (R12) single address match trigger
  assign hit = exec_en_ff & fetch_valid & ~in_debug & (fetch_pc == match_addr_ff);

endmodule

// ===== core/dbg_status.sv
`timescale 1ns/10ps
module dbg_status (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // inputs
  input  wire logic fetch_permit,
  input  wire logic req_pending,
  input  wire logic in_debug,
  // status
  output logic      released,
  output logic      st_havereset,
  output logic      st_running,
  output logic      st_halted
);

  dbg_pkg::dbg_state_t state_ff;
  dbg_pkg::dbg_state_t nxt_state;
  logic [1:0]          cnt_ff;
  logic [1:0]          nxt_cnt;
  logic                cnt_done;

  assign cnt_done = (cnt_ff == 2'(dbg_pkg::HAVERESET_CYC - 1));

  // (R14) unavailable until permit then a few cycles
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      dbg_pkg::ST_RESET: begin
        if (fetch_permit) nxt_state = dbg_pkg::ST_WAIT;
      end
      dbg_pkg::ST_WAIT: begin
        nxt_cnt = cnt_ff + 2'h1;
        // (R15) early request goes straight to halted
        if (cnt_done) nxt_state = req_pending ? dbg_pkg::ST_HALT : dbg_pkg::ST_RUN;
      end
      // (R7) halted tracks debug mode
      dbg_pkg::ST_RUN:  if (in_debug) nxt_state = dbg_pkg::ST_HALT;
      // an early request still being taken keeps halted, never a running blip
      dbg_pkg::ST_HALT: if (!in_debug && !req_pending) nxt_state = dbg_pkg::ST_RUN;
      default: nxt_state = dbg_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= dbg_pkg::ST_RESET;
      cnt_ff   <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // (R5) one-hot status from state
  assign st_havereset = state_ff[0] | state_ff[1];
  assign st_running   = state_ff[2];
  assign st_halted    = state_ff[3];
  assign released     = state_ff[2] | state_ff[3];

  // (R5)
  a_status_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot({st_havereset, st_running, st_halted}))
    else $error("status lines not one-hot");
  // (R6)
  a_reset_havereset: assert property (@(posedge clk) !nrst |=> st_havereset)
    else $error("have-reset low after reset");

endmodule

// ===== core/core_debug_entry_control.sv
`timescale 1ns/10ps
// How it works
// (R1) request: enter debug, save pc, cause, vector
// (R2) entry by request, trigger or breakpoint
// (R3) request synchronous, held one cycle minimum
// (R4) decoded instruction killed on request rise
// (R5) status lines exactly one-hot
// (R6) have-reset high in reset, clears later
// (R7) halted in debug, else running
// (R8) entries and debug breakpoints use halt vector
// (R9) debug exceptions and mret use exception vector
// (R10) vectors supplied word aligned
// (R11) debug csrs illegal outside debug mode
// (R12) one instruction address match trigger
// (R13) debug-only bit one, writes gated
// (R14) unavailable until release and fetch permit
// (R15) early request goes unavailable to halted
// (R16) running request reaches halted in cycles
// (R17) breakpoint without bit traps to machine
// (R18) breakpoint with bit enters debug mode
// (R19) breakpoint in debug restarts, csrs kept
// (R20) breakpoint bit resets to zero
// (R21) debugger advances saved pc past breakpoint
// (R22) no illegal for program buffer transfers
// (R23) interrupts ignored in debug mode
// (R24) debug return restores pc, runs again
module core_debug_entry_control #(
  parameter int XLEN = 32
) (
  // clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   NRST,
  // debug module side
  input  wire logic                   DEBUG_REQ,
  input  wire logic                   FETCH_PERMIT,
  input  wire logic [XLEN-1:0]        HALT_ENTRY_VECTOR,
  input  wire logic [XLEN-1:0]        DEBUG_EXCEPTION_VECTOR,
  input  wire logic [XLEN-1:0]        MACHINE_TRAP_VECTOR,
  output logic                        DEBUG_HAVERESET,
  output logic                        DEBUG_RUNNING,
  output logic                        DEBUG_HALTED,
  // pipeline side
  input  wire dbg_pkg::retire_t       RETIRE,
  input  wire logic [XLEN-1:0]        FETCH_PC,
  input  wire logic                   FETCH_VALID,
  input  wire logic                   IRQ_PENDING,
  input  wire dbg_pkg::csr_req_t      CSR_REQ,
  output logic [XLEN-1:0]             CSR_RDATA,
  output logic                        CSR_ILLEGAL,
  output logic                        KILL_DECODE,
  output logic                        PC_LOAD,
  output logic [XLEN-1:0]             PC_TARGET,
  output logic                        IRQ_TAKE,
  output logic                        DEBUG_MODE,
  // machine trap state
  output logic [XLEN-1:0]             EXCEPTION_PC,
  output logic [XLEN-1:0]             EXCEPTION_CAUSE
);

  logic            mode_ff;
  logic            req_ff;
  logic            pend_ff;
  logic            brk_bit_ff;
  logic [2:0]      cause_ff;
  logic [XLEN-1:0] dpc_ff;
  logic [XLEN-1:0] scr0_ff;
  logic [XLEN-1:0] scr1_ff;
  logic [XLEN-1:0] epc_ff;
  logic [XLEN-1:0] ecause_ff;
  logic            kill_ff;
  logic            pc_load_ff;
  logic [XLEN-1:0] pc_tgt_ff;
  logic            irq_ff;
  logic            ill_ff;
  logic [XLEN-1:0] rdata_ff;
  logic            hav_ff;
  logic            run_ff;
  logic            hlt_ff;

  // status block and trigger wires
  logic            released;
  logic            st_hav;
  logic            st_run;
  logic            st_hlt;
  logic            trig_hit;
  logic [XLEN-1:0] td1_rd;
  logic [XLEN-1:0] td2_rd;

  // decode of entry sources
  logic            req_rise;
  logic            brk_to_dbg;
  logic            brk_trap;
  logic            brk_in_dbg;
  logic            exc_in_dbg;
  logic            ret_in_dbg;
  logic            dret;
  logic            req_entry;
  logic            entry;
  logic [2:0]      entry_cause;
  logic [XLEN-1:0] entry_pc;
  logic            csr_dbg_sel;
  logic            csr_bad;
  logic            csr_wr;
  logic            wr_td1;
  logic            wr_td2;
  logic [XLEN-1:0] dcsr_rd;
  logic [XLEN-1:0] csr_mux;

  // (R4) the request edge kills decode
  assign req_rise    = DEBUG_REQ & ~req_ff & ~mode_ff;
  // (R18) breakpoint with bit set enters debug
  assign brk_to_dbg  = RETIRE.valid & RETIRE.is_ebreak & ~mode_ff & brk_bit_ff;
  // (R17) breakpoint with bit clear traps
  assign brk_trap    = RETIRE.valid & RETIRE.is_ebreak & ~mode_ff & ~brk_bit_ff;
  // (R19) breakpoint in debug restarts only
  assign brk_in_dbg  = RETIRE.valid & RETIRE.is_ebreak & mode_ff;
  // (R9) exception and returns inside debug
  assign exc_in_dbg  = RETIRE.valid & RETIRE.except & mode_ff;
  assign ret_in_dbg  = RETIRE.valid & RETIRE.is_mret & mode_ff;
  assign dret        = RETIRE.valid & RETIRE.is_dret & mode_ff;
  // (R16) pending request is taken once released
  assign req_entry   = pend_ff & released & ~mode_ff;
  // (R2) three entry sources
  assign entry       = req_entry | trig_hit | brk_to_dbg;
  assign entry_cause = brk_to_dbg ? dbg_pkg::CAUSE_BREAK :
                       trig_hit   ? dbg_pkg::CAUSE_TRIGGER : dbg_pkg::CAUSE_REQUEST;
  // breakpoint saves its own pc; the debugger must step past it
  // (R21) saved pc left on the breakpoint
  assign entry_pc    = brk_to_dbg ? RETIRE.pc : (RETIRE.valid ? RETIRE.next_pc : FETCH_PC);

  // (R11) debug csrs only in debug; triggers readable
  assign csr_dbg_sel = (CSR_REQ.sel == dbg_pkg::SEL_DCSR) | (CSR_REQ.sel == dbg_pkg::SEL_DPC) |
                       (CSR_REQ.sel == dbg_pkg::SEL_SCR0) | (CSR_REQ.sel == dbg_pkg::SEL_SCR1);
  assign csr_bad     = CSR_REQ.req & csr_dbg_sel & ~mode_ff;
  assign csr_wr      = CSR_REQ.req & CSR_REQ.we & mode_ff;
  assign wr_td1      = CSR_REQ.req & CSR_REQ.we & (CSR_REQ.sel == dbg_pkg::SEL_TD1);
  assign wr_td2      = CSR_REQ.req & CSR_REQ.we & (CSR_REQ.sel == dbg_pkg::SEL_TD2);

  assign dcsr_rd = (XLEN'(dbg_pkg::DCS_XDEBUG) << dbg_pkg::DCS_XDBG_LSB) |
                   (XLEN'(brk_bit_ff) << dbg_pkg::DCS_BRK_BIT) |
                   (XLEN'(cause_ff) << dbg_pkg::DCS_CAUSE_LSB) |
                   (XLEN'(dbg_pkg::PRV_MACHINE) << dbg_pkg::DCS_PRV_LSB);

  assign csr_mux = (CSR_REQ.sel == dbg_pkg::SEL_DCSR) ? dcsr_rd :
                   (CSR_REQ.sel == dbg_pkg::SEL_DPC)  ? dpc_ff  :
                   (CSR_REQ.sel == dbg_pkg::SEL_SCR0) ? scr0_ff :
                   (CSR_REQ.sel == dbg_pkg::SEL_SCR1) ? scr1_ff :
                   (CSR_REQ.sel == dbg_pkg::SEL_TD1)  ? td1_rd  :
                   (CSR_REQ.sel == dbg_pkg::SEL_TD2)  ? td2_rd  : '0;

  dbg_trigger #(
    .XLEN        (XLEN)
  ) u_trig (
    .clk         (MCLK),
    .nrst        (NRST),
    .wr_td1      (wr_td1),
    .wr_td2      (wr_td2),
    .wdata       (CSR_REQ.wdata),
    .in_debug    (mode_ff),
    .fetch_pc    (FETCH_PC),
    .fetch_valid (FETCH_VALID & released),
    .td1_rd      (td1_rd),
    .td2_rd      (td2_rd),
    .hit         (trig_hit)
  );

  dbg_status u_stat (
    .clk          (MCLK),
    .nrst         (NRST),
    .fetch_permit (FETCH_PERMIT),
    .req_pending  (pend_ff | DEBUG_REQ),
    .in_debug     (mode_ff),
    .released     (released),
    .st_havereset (st_hav),
    .st_running   (st_run),
    .st_halted    (st_hlt)
  );

  // request edge, and a pending flag held until taken; clear wins
  // (R3) a one-cycle request is remembered
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      req_ff  <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      req_ff  <= DEBUG_REQ;
      // cleared by any entry and held clear in debug, so a request dropped before return cannot re-enter
      pend_ff <= (DEBUG_REQ | pend_ff) & ~mode_ff & ~entry;
    end
  end

  // (R1) mode, saved pc and cause on entry
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      mode_ff  <= 1'b0;
      dpc_ff   <= '0;
      cause_ff <= dbg_pkg::CAUSE_NONE;
    end else if (entry) begin
      mode_ff  <= 1'b1;
      dpc_ff   <= entry_pc;
      cause_ff <= entry_cause;
    end else if (dret) begin
      // (R24) return leaves debug mode
      mode_ff  <= 1'b0;
    end else if (csr_wr & (CSR_REQ.sel == dbg_pkg::SEL_DPC)) begin
      dpc_ff   <= CSR_REQ.wdata;
    end
  end

  // (R20) breakpoint bit resets low
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      brk_bit_ff <= 1'b0;
      scr0_ff    <= '0;
      scr1_ff    <= '0;
    end else if (csr_wr) begin
      if (CSR_REQ.sel == dbg_pkg::SEL_DCSR) brk_bit_ff <= CSR_REQ.wdata[dbg_pkg::DCS_BRK_BIT];
      if (CSR_REQ.sel == dbg_pkg::SEL_SCR0) scr0_ff <= CSR_REQ.wdata;
      if (CSR_REQ.sel == dbg_pkg::SEL_SCR1) scr1_ff <= CSR_REQ.wdata;
    end
  end

  // (R17) machine trap state for breakpoint traps and illegal debug csr accesses
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      epc_ff    <= '0;
      ecause_ff <= '0;
    end else if (brk_trap) begin
      epc_ff    <= RETIRE.pc;
      ecause_ff <= dbg_pkg::CAUSE_CODE_BREAK;
    end else if (csr_bad) begin
      epc_ff    <= RETIRE.pc;
      ecause_ff <= dbg_pkg::CAUSE_CODE_ILLEGAL;
    end
  end

  // pc redirect; the vector low bits are trusted, not masked
  // (R10) vectors assumed word aligned
  // (R8) entry vectors to halt address
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pc_load_ff <= 1'b0;
      pc_tgt_ff  <= '0;
    end else begin
      pc_load_ff <= entry | brk_in_dbg | exc_in_dbg | ret_in_dbg | dret | brk_trap;
      if (entry | brk_in_dbg) pc_tgt_ff <= HALT_ENTRY_VECTOR;
      // (R9) exceptions in debug to exception vector
      else if (exc_in_dbg | ret_in_dbg) pc_tgt_ff <= DEBUG_EXCEPTION_VECTOR;
      else if (dret) pc_tgt_ff <= dpc_ff;
      else if (brk_trap) pc_tgt_ff <= MACHINE_TRAP_VECTOR;
    end
  end

  // (R22) only debug csr selects can be illegal
  // (R23) interrupts masked in debug
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      kill_ff  <= 1'b0;
      irq_ff   <= 1'b0;
      ill_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      kill_ff  <= req_rise | entry;
      irq_ff   <= IRQ_PENDING & ~mode_ff & ~entry & released;
      ill_ff   <= csr_bad;
      rdata_ff <= csr_bad ? '0 : csr_mux;
    end
  end

  // status registered once more so outputs come from flops
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      hav_ff <= 1'b1;
      run_ff <= 1'b0;
      hlt_ff <= 1'b0;
    end else begin
      hav_ff <= st_hav;
      run_ff <= st_run;
      hlt_ff <= st_hlt;
    end
  end

  assign DEBUG_HAVERESET = hav_ff;
  assign DEBUG_RUNNING   = run_ff;
  assign DEBUG_HALTED    = hlt_ff;
  assign KILL_DECODE     = kill_ff;
  assign PC_LOAD         = pc_load_ff;
  assign PC_TARGET       = pc_tgt_ff;
  assign IRQ_TAKE        = irq_ff;
  assign DEBUG_MODE      = mode_ff;
  assign CSR_RDATA       = rdata_ff;
  assign CSR_ILLEGAL     = ill_ff;
  assign EXCEPTION_PC    = epc_ff;
  assign EXCEPTION_CAUSE = ecause_ff;

  a_entry_vector: assert property (@(posedge MCLK) disable iff (!NRST) // (R8)
    entry |=> PC_LOAD && PC_TARGET == $past(HALT_ENTRY_VECTOR))
    else $error("entry did not vector to halt address");
  a_entry_mode: assert property (@(posedge MCLK) disable iff (!NRST) // (R1)
    entry |=> mode_ff && dpc_ff == $past(entry_pc))
    else $error("entry did not save pc");
  a_kill_decode: assert property (@(posedge MCLK) disable iff (!NRST) // (R4)
    req_rise |=> KILL_DECODE)
    else $error("decode not killed");
  a_csr_illegal: assert property (@(posedge MCLK) disable iff (!NRST) // (R11)
    (CSR_REQ.req && !mode_ff && CSR_REQ.sel == dbg_pkg::SEL_DPC) |=> CSR_ILLEGAL)
    else $error("debug csr access not illegal");
  a_trap_no_debug: assert property (@(posedge MCLK) disable iff (!NRST) // (R17)
    brk_trap |=> !mode_ff && EXCEPTION_CAUSE == dbg_pkg::CAUSE_CODE_BREAK)
    else $error("breakpoint trap wrong");
  a_brk_debug_keep: assert property (@(posedge MCLK) disable iff (!NRST) // (R19)
    brk_in_dbg |=> mode_ff && $stable(dpc_ff) && $stable(cause_ff))
    else $error("breakpoint in debug changed state");
  a_irq_masked: assert property (@(posedge MCLK) disable iff (!NRST) // (R23)
    mode_ff |=> !IRQ_TAKE)
    else $error("interrupt taken in debug");
  a_halt_within: assert property (@(posedge MCLK) disable iff (!NRST) // (R16)
    (DEBUG_REQ && DEBUG_RUNNING) |-> ##[1:6] DEBUG_HALTED)
    else $error("request did not halt");
  a_dret_run: assert property (@(posedge MCLK) disable iff (!NRST) // (R24)
    (dret && !entry) |=> !mode_ff ##3 DEBUG_RUNNING)
    else $error("return did not resume");

endmodule

// ===== verification/dbg_host_model.sv
`timescale 1ns/10ps
module dbg_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // bench command and core status
  input  wire logic go,
  input  wire logic halted,
  output logic      req
);
  // synchronous request hold
  // held until halted is seen, so the core never sees a request shorter than a cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req <= 1'b0;
    end else if (go) begin
      req <= 1'b1;
    end else if (halted) begin
      req <= 1'b0;
    end
  end
endmodule

// ===== verification/tb_core_debug_entry_control.sv
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb_core_debug_entry_control;
  localparam logic [31:0] HALT_V = 32'h0000_0800;
  localparam logic [31:0] EXC_V  = 32'h0000_0808;
  localparam logic [31:0] MTV_V  = 32'h0000_0100;
  localparam logic [31:0] FPC0   = 32'h0000_0040;
  // stimulus and observed wires
  logic              MCLK, NRST, DEBUG_REQ, FETCH_PERMIT, FETCH_VALID, IRQ_PENDING, go;
  logic              DEBUG_HAVERESET, DEBUG_RUNNING, DEBUG_HALTED, CSR_ILLEGAL, KILL_DECODE;
  logic              PC_LOAD, IRQ_TAKE, DEBUG_MODE, ill, mon_on;
  logic [31:0]       FETCH_PC, CSR_RDATA, PC_TARGET, EXCEPTION_PC, EXCEPTION_CAUSE, rd, d0;
  dbg_pkg::retire_t  RETIRE;
  dbg_pkg::csr_req_t CSR_REQ;
  int                n_fail, checks, runs;

  core_debug_entry_control i_core_debug_entry_control (
    .MCLK(MCLK), .NRST(NRST), .DEBUG_REQ(DEBUG_REQ), .FETCH_PERMIT(FETCH_PERMIT),
    .HALT_ENTRY_VECTOR(HALT_V), .DEBUG_EXCEPTION_VECTOR(EXC_V), .MACHINE_TRAP_VECTOR(MTV_V),
    .DEBUG_HAVERESET(DEBUG_HAVERESET), .DEBUG_RUNNING(DEBUG_RUNNING),
    .DEBUG_HALTED(DEBUG_HALTED), .RETIRE(RETIRE), .FETCH_PC(FETCH_PC),
    .FETCH_VALID(FETCH_VALID), .IRQ_PENDING(IRQ_PENDING), .CSR_REQ(CSR_REQ),
    .CSR_RDATA(CSR_RDATA), .CSR_ILLEGAL(CSR_ILLEGAL), .KILL_DECODE(KILL_DECODE),
    .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET), .IRQ_TAKE(IRQ_TAKE), .DEBUG_MODE(DEBUG_MODE),
    .EXCEPTION_PC(EXCEPTION_PC), .EXCEPTION_CAUSE(EXCEPTION_CAUSE)
  );

  dbg_host_model i_dbg_host_model (
    .clk(MCLK), .nrst(NRST), .go(go), .halted(DEBUG_HALTED), .req(DEBUG_REQ)
  );

  // 25 MHz core clock
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // bounded wait for a watched output; returns just after the edge that showed it
  task automatic wait_hi(input int which);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 20 && !hit; i++) begin
      #1;
      case (which)
        0: hit = (PC_LOAD === 1'b1);
        1: hit = (KILL_DECODE === 1'b1);
        2: hit = (DEBUG_HALTED === 1'b1);
        default: hit = (DEBUG_RUNNING === 1'b1);
      endcase
      if (!hit) begin
        if (DEBUG_RUNNING === 1'b1) runs++;
        @(posedge MCLK);
      end
    end
    if (!hit) begin
      n_fail++;
      $display("CHECK FAILED t=%0t wait %0d ran out", $time, which);
      tally_and_finish();
    end
  endtask

  // one csr access; read data and illegal flag stand one cycle after the request edge
  task automatic csr(input logic we, input logic [2:0] sel, input logic [31:0] wd,
                     output logic [31:0] q, output logic bad);
    @(posedge MCLK);
    CSR_REQ <= '{req: 1'b1, we: we, sel: sel, wdata: wd};
    @(posedge MCLK);
    CSR_REQ <= '0;
    #1;
    q = CSR_RDATA;
    bad = CSR_ILLEGAL;
  endtask

  // retire one instruction (kind: 1 ebreak, 2 mret, 4 dret, 8 exception) and check the jump
  task automatic retire_to(input logic [31:0] pc, input logic [3:0] kind,
                           input logic [31:0] exp);
    @(posedge MCLK);
    RETIRE <= '{valid: 1'b1, pc: pc, next_pc: pc + 32'h0000_0004, is_ebreak: kind[0],
                is_mret: kind[1], is_dret: kind[2], except: kind[3]};
    @(posedge MCLK);
    RETIRE <= '0;
    wait_hi(0);
    `CHK(PC_TARGET, exp, "jump target")
  endtask

  task automatic t_early_request();
    @(posedge MCLK);
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    tick(3);
    #1;
    `CHK({DEBUG_HAVERESET, DEBUG_RUNNING, DEBUG_HALTED}, 3'b100, "unavailable")
    @(posedge MCLK);
    FETCH_PERMIT <= 1'b1;
    runs = 0;
    wait_hi(0);
    `CHK(PC_TARGET, HALT_V, "entry vector")
    wait_hi(2);
    `CHK(runs, 0, "ran before halt")
    `CHK(DEBUG_HAVERESET, 1'b0, "havereset clear")
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, rd, ill);
    `CHK(rd[dbg_pkg::DCS_CAUSE_LSB +: 3], dbg_pkg::CAUSE_REQUEST, "request cause")
    `CHK(rd[dbg_pkg::DCS_BRK_BIT], 1'b0, "break bit reset")
    csr(1'b0, dbg_pkg::SEL_DPC, '0, rd, ill);
    `CHK(rd, FPC0, "saved pc")
  endtask

  task automatic t_dret();
    csr(1'b1, dbg_pkg::SEL_DPC, 32'h0000_0200, rd, ill);
    retire_to(32'h0000_0804, 4'h4, 32'h0000_0200);
    wait_hi(3);
    `CHK(DEBUG_MODE, 1'b0, "left debug")
  endtask

  task automatic t_break_trap();
    retire_to(32'h0000_0500, 4'h1, MTV_V);
    `CHK(EXCEPTION_PC, 32'h0000_0500, "trap pc")
    `CHK(EXCEPTION_CAUSE, dbg_pkg::CAUSE_CODE_BREAK, "trap cause")
    `CHK(DEBUG_MODE, 1'b0, "no debug entry")
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, rd, ill);
    `CHK(ill, 1'b1, "debug csr outside")
    `CHK(EXCEPTION_CAUSE, dbg_pkg::CAUSE_CODE_ILLEGAL, "illegal cause")
    csr(1'b0, dbg_pkg::SEL_TD2, '0, d0, ill);
    csr(1'b1, dbg_pkg::SEL_TD2, 32'h0000_0700, rd, ill);
    csr(1'b0, dbg_pkg::SEL_TD2, '0, rd, ill);
    `CHK(rd, d0, "trigger write ignored")
    `CHK(ill, 1'b0, "trigger read legal")
    @(posedge MCLK);
    IRQ_PENDING <= 1'b1;
    tick(3);
    #1;
    `CHK(IRQ_TAKE, 1'b1, "irq taken running")
    @(posedge MCLK);
    IRQ_PENDING <= 1'b0;
  endtask

  task automatic t_request_running();
    @(posedge MCLK);
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    wait_hi(1);
    `CHK(KILL_DECODE, 1'b1, "decode killed")
    wait_hi(0);
    `CHK(PC_TARGET, HALT_V, "request entry")
    wait_hi(2);
    `CHK(DEBUG_MODE, 1'b1, "in debug")
  endtask

  task automatic t_in_debug();
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, d0, ill);
    retire_to(32'h0000_0810, 4'h1, HALT_V);
    retire_to(32'h0000_0814, 4'h2, EXC_V);
    retire_to(32'h0000_0818, 4'h8, EXC_V);
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, rd, ill);
    `CHK(rd, d0, "csr untouched")
    `CHK(DEBUG_HALTED, 1'b1, "still halted")
    @(posedge MCLK);
    IRQ_PENDING <= 1'b1;
    tick(3);
    #1;
    `CHK(IRQ_TAKE, 1'b0, "irq ignored")
    @(posedge MCLK);
    IRQ_PENDING <= 1'b0;
    // debug-only bit written as zero must still read one
    csr(1'b1, dbg_pkg::SEL_TD1, 32'h2000_0004, rd, ill);
    csr(1'b1, dbg_pkg::SEL_TD2, 32'h0000_0300, rd, ill);
    csr(1'b0, dbg_pkg::SEL_TD1, '0, rd, ill);
    `CHK(rd[dbg_pkg::TD1_TRIGGER_DEBUG_ONLY_BIT], 1'b1, "debug-only bit")
    `CHK(rd[dbg_pkg::TD1_TYPE_LSB +: 4], dbg_pkg::TD1_TYPE_MATCH, "match type")
    csr(1'b1, dbg_pkg::SEL_DCSR, 32'h0000_8000, rd, ill);
    csr(1'b0, dbg_pkg::SEL_DPC, '0, d0, ill);
    retire_to(32'h0000_081c, 4'h4, d0);
    wait_hi(3);
  endtask

  task automatic t_break_debug();
    d0 = EXCEPTION_PC;
    retire_to(32'h0000_0600, 4'h1, HALT_V);
    wait_hi(2);
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, rd, ill);
    `CHK(rd[dbg_pkg::DCS_CAUSE_LSB +: 3], dbg_pkg::CAUSE_BREAK, "break cause")
    csr(1'b0, dbg_pkg::SEL_DPC, '0, rd, ill);
    `CHK(rd, 32'h0000_0600, "break pc")
    `CHK(EXCEPTION_PC, d0, "handler skipped")
    // debugger steps the saved pc past the 32-bit breakpoint
    csr(1'b1, dbg_pkg::SEL_DPC, 32'h0000_0604, rd, ill);
    retire_to(32'h0000_0820, 4'h4, 32'h0000_0604);
    wait_hi(3);
  endtask

  task automatic t_trigger();
    @(posedge MCLK);
    FETCH_PC <= 32'h0000_0300;
    FETCH_VALID <= 1'b1;
    wait_hi(0);
    `CHK(PC_TARGET, HALT_V, "trigger entry")
    @(posedge MCLK);
    FETCH_VALID <= 1'b0;
    wait_hi(2);
    csr(1'b0, dbg_pkg::SEL_DCSR, '0, rd, ill);
    `CHK(rd[dbg_pkg::DCS_CAUSE_LSB +: 3], dbg_pkg::CAUSE_TRIGGER, "trigger cause")
  endtask

  // status watch; enabled after four reset edges so power-up unknowns are not judged
  always @(negedge MCLK) begin
    if (mon_on) begin
      `CHK((DEBUG_HAVERESET + DEBUG_RUNNING + DEBUG_HALTED) === 2'd1, 1'b1, "one-hot")
    end
  end

  // main sequence
  initial begin
    NRST = 1'b0;
    go = 1'b0;
    FETCH_PERMIT = 1'b0;
    FETCH_PC = FPC0;
    FETCH_VALID = 1'b0;
    IRQ_PENDING = 1'b0;
    RETIRE = '0;
    CSR_REQ = '0;
    n_fail = 0;
    checks = 0;
    runs = 0;
    mon_on = 1'b0;
    tick(4);
    #1;
    `CHK(DEBUG_HAVERESET, 1'b1, "havereset in reset")
    mon_on = 1'b1;
    @(posedge MCLK);
    NRST <= 1'b1;
    t_early_request();
    t_dret();
    t_break_trap();
    t_request_running();
    t_in_debug();
    t_break_debug();
    t_trigger();
    tally_and_finish();
  end
endmodule
